// >>> include/nsc_pkg.sv
package nsc_pkg;
	// Byte offsets of the controller's own registers on the APB side.
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_ROW  = 12'h004;
	localparam logic [11:0] ADDR_COL  = 12'h008;
	localparam logic [11:0] ADDR_PD   = 12'h00C;
	localparam logic [11:0] ADDR_STAT = 12'h010;
	localparam logic [11:0] ADDR_DATA = 12'h014;

	// Field positions in the control and status words.
	localparam int CTRL_OP_LSB    = 0;
	localparam int CTRL_MULTI_BIT = 4;
	localparam int CTRL_OTP_BIT   = 5;
	localparam int STAT_BUSY_BIT  = 8;
	localparam int STAT_REF_BIT   = 9;
	localparam int STAT_SEL_BIT   = 10;
	localparam int STAT_RB_BIT    = 11;

	// Operation codes that software writes into the control word.
	localparam logic [2:0] OP_NONE       = 3'h0;
	localparam logic [2:0] OP_SET_PD     = 3'h1;
	localparam logic [2:0] OP_STATUS     = 3'h2;
	localparam logic [2:0] OP_STATUS_ENH = 3'h3;
	localparam logic [2:0] OP_COL_READ   = 3'h4;
	localparam logic [2:0] OP_READ_MODE  = 3'h5;

	// Command and feature bytes sent to the flash.
	localparam logic [7:0] CMD_SET_FEAT    = 8'hEF;
	localparam logic [7:0] FEAT_PULLDOWN   = 8'h81;
	localparam logic [7:0] PARAM_RESERVED  = 8'h00;
	localparam logic [7:0] CMD_STATUS      = 8'h70;
	localparam logic [7:0] CMD_STATUS_ENH  = 8'h78;
	localparam logic [7:0] CMD_COL_READ    = 8'h05;
	localparam logic [7:0] CMD_COL_CONFIRM = 8'hE0;
	localparam logic [7:0] CMD_READ_MODE   = 8'h00;

	// Pull-down reset strength code and the die-ready status bit.
	localparam logic [1:0] PD_FULL = 2'h0;
	localparam int SR_DIE_READY = 6;

	// Timing, in nanoseconds, and the clock period.
	localparam int CLK_NS     = 20;
	localparam int T_STROBE_NS = 40;
	localparam int T_WHR_NS    = 80;
	localparam int T_FEAT_NS   = 1000;
	// Least times round up to whole cycles.
	localparam int STROBE_CYC = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int WHR_CYC    = (T_WHR_NS + CLK_NS - 1) / CLK_NS;
	localparam int FEAT_CYC   = (T_FEAT_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W      = 8;

	// Kinds of step in a command sequence.
	typedef enum logic [2:0] {
		K_CMD, K_ADDR, K_DIN, K_WHR, K_READ, K_BUSY, K_END
	} nsc_kind_t;

	// One step of a sequence: what to do and which byte to send.
	typedef struct packed {
		nsc_kind_t  kind;
		logic [7:0] data;
	} nsc_item_t;

	// Flash-facing pin bundle driven by the controller.
	typedef struct packed {
		logic       ce_n;
		logic       cle;
		logic       ale;
		logic       we_n;
		logic       re_n;
		logic [7:0] io_out;
		logic       io_oe;
	} nsc_pins_t;

	// Sequencer states.
	typedef enum logic [2:0] {
		S_IDLE, S_NEXT, S_STRB, S_LOW, S_HIGH, S_WAIT, S_BUSY
	} nsc_state_t;

	// Whole state of the controller.
	typedef struct packed {
		nsc_state_t       st;
		logic [2:0]       op;
		logic [3:0]       step;
		logic [CNT_W-1:0] cnt;
		logic [23:0]      row;
		logic [15:0]      col;
		logic [1:0]       pd;
		logic             multi_die;
		logic             otp_block;
		logic             die_sel;
		logic             refused;
		logic [7:0]       status_byte;
		logic [7:0]       data_byte;
		nsc_pins_t        pins;
	} nsc_regs_t;
endpackage : nsc_pkg

// >>> design/nsc_host.sv
// Overview of operation
// R1 - Feature 81h first param sets pull-down strength
// R2 - Pull-down defaults to full strength
// R3 - Each die keeps its own status byte
// R4 - Status commands return status on reads
// R5 - Status changes visible while strobes low
// R6 - Host issues 00h before reading page data
// R7 - Status bit 7 reports write protection
// R8 - Ready bits per die, fail bits per plane
// R9 - Bit 0 failure valid when array ready
// R10 - Bit 1 previous failure valid when die ready
// R11 - Bits 4:3 give read ECC result
// R12 - Bit 0 flags uncorrectable read error
// R13 - 70h returns last-selected die, even busy
// R14 - Multi-die hosts use 78h, not 70h
// R15 - 78h takes three row address bytes
// R16 - All dies accept 78h, others deselect
// R17 - Wait die ready, then 00h before data
// R18 - No 78h during power-on reset or OTP (code refuses 78h only while the OTP bit is set)
// R19 - Column address reaches any cache byte
// R20 - Column read accepted ready or cache-reading
// R21 - 05h, two columns, E0h, wait before output
// R22 - Die stays in output after column read
// R23 - Multi-die hosts send 78h before 05h-E0h
// R24 - Status bit 2 and zero bits drive zero
// R25 - EFh, address, four params, then busy
`timescale 1ns/100ps
`default_nettype none

module nsc_host (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [11:0]        paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	output nsc_pkg::nsc_pins_t      nand_pins,
	input  wire logic [7:0]         nand_io_in,
	input  wire logic               ready_busy_n
);
	// Counts must fit the counter; refuse otherwise.
	if (nsc_pkg::FEAT_CYC >= (1 << nsc_pkg::CNT_W) ||
	    nsc_pkg::WHR_CYC >= (1 << nsc_pkg::CNT_W)) begin : g_chk
		$error("Timing count does not fit the counter.");
	end

	nsc_pkg::nsc_regs_t q;      // Registered state.
	nsc_pkg::nsc_regs_t n;      // Next state.
	nsc_pkg::nsc_item_t item;   // Current sequence step.
	logic               wr_acc; // APB write access phase.
	logic               mapped; // Address hits a register.
	localparam int CNT_W = nsc_pkg::CNT_W; // Width of the timing counter.

	// Returns the step of an operation's sequence at a given index.
	function automatic nsc_pkg::nsc_item_t seq_item(
		input logic [2:0]  op,
		input logic [3:0]  step,
		input logic [23:0] row,
		input logic [15:0] col,
		input logic [1:0]  pd);
		nsc_pkg::nsc_item_t it;
		it = '{kind: nsc_pkg::K_END, data: nsc_pkg::PARAM_RESERVED};
		unique case (op)
			nsc_pkg::OP_SET_PD: begin
				// Command, feature address, P1 then three zero params. [R25]
				unique case (step)
					4'h0: it = '{nsc_pkg::K_CMD, nsc_pkg::CMD_SET_FEAT};
					4'h1: it = '{nsc_pkg::K_ADDR, nsc_pkg::FEAT_PULLDOWN};
					4'h2: it = '{nsc_pkg::K_DIN, {6'h00, pd}}; // [R1]
					4'h3, 4'h4, 4'h5:
						it = '{nsc_pkg::K_DIN, nsc_pkg::PARAM_RESERVED};
					4'h6: it = '{nsc_pkg::K_BUSY, nsc_pkg::PARAM_RESERVED};
					default: ;
				endcase
			end
			nsc_pkg::OP_STATUS: begin
				unique case (step)
					4'h0: it = '{nsc_pkg::K_CMD, nsc_pkg::CMD_STATUS}; // [R13]
					4'h1: it = '{nsc_pkg::K_WHR, nsc_pkg::PARAM_RESERVED};
					4'h2: it = '{nsc_pkg::K_READ, nsc_pkg::PARAM_RESERVED};
					default: ;
				endcase
			end
			nsc_pkg::OP_STATUS_ENH: begin
				// Three row bytes, low byte first, pick the die. [R15]
				unique case (step)
					4'h0: it = '{nsc_pkg::K_CMD, nsc_pkg::CMD_STATUS_ENH};
					4'h1: it = '{nsc_pkg::K_ADDR, row[7:0]};
					4'h2: it = '{nsc_pkg::K_ADDR, row[15:8]};
					4'h3: it = '{nsc_pkg::K_ADDR, row[23:16]};
					4'h4: it = '{nsc_pkg::K_WHR, nsc_pkg::PARAM_RESERVED};
					4'h5: it = '{nsc_pkg::K_READ, nsc_pkg::PARAM_RESERVED};
					default: ;
				endcase
			end
			nsc_pkg::OP_COL_READ: begin
				// Any byte column, then confirm and wait. [R19] [R21]
				unique case (step)
					4'h0: it = '{nsc_pkg::K_CMD, nsc_pkg::CMD_COL_READ};
					4'h1: it = '{nsc_pkg::K_ADDR, col[7:0]};
					4'h2: it = '{nsc_pkg::K_ADDR, col[15:8]};
					4'h3: it = '{nsc_pkg::K_CMD, nsc_pkg::CMD_COL_CONFIRM};
					4'h4: it = '{nsc_pkg::K_WHR, nsc_pkg::PARAM_RESERVED};
					4'h5: it = '{nsc_pkg::K_READ, nsc_pkg::PARAM_RESERVED};
					default: ;
				endcase
			end
			nsc_pkg::OP_READ_MODE: begin
				if (step == 4'h0) begin
					it = '{nsc_pkg::K_CMD, nsc_pkg::CMD_READ_MODE}; // [R6]
				end
			end
			default: ;
		endcase
		return it;
	endfunction : seq_item

	// Slave always answers at once; unmapped addresses raise an error.
	assign mapped  = (paddr == nsc_pkg::ADDR_CTRL) ||
	                 (paddr == nsc_pkg::ADDR_ROW)  ||
	                 (paddr == nsc_pkg::ADDR_COL)  ||
	                 (paddr == nsc_pkg::ADDR_PD)   ||
	                 (paddr == nsc_pkg::ADDR_STAT) ||
	                 (paddr == nsc_pkg::ADDR_DATA);
	assign wr_acc  = psel && penable && pwrite && mapped;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign nand_pins = q.pins;

	// Read mux over registered state and the ready/busy pin.
	always_comb begin
		prdata = 32'h0000_0000;
		unique case (paddr)
			nsc_pkg::ADDR_CTRL: begin
				prdata[nsc_pkg::CTRL_OP_LSB +: 3] = q.op;
				prdata[nsc_pkg::CTRL_MULTI_BIT]   = q.multi_die;
				prdata[nsc_pkg::CTRL_OTP_BIT]     = q.otp_block;
			end
			nsc_pkg::ADDR_ROW:  prdata[23:0] = q.row;
			nsc_pkg::ADDR_COL:  prdata[15:0] = q.col;
			nsc_pkg::ADDR_PD:   prdata[1:0]  = q.pd;
			nsc_pkg::ADDR_STAT: begin
				prdata[7:0] = q.status_byte;
				prdata[nsc_pkg::STAT_BUSY_BIT] = (q.st != nsc_pkg::S_IDLE);
				prdata[nsc_pkg::STAT_REF_BIT]  = q.refused;
				prdata[nsc_pkg::STAT_SEL_BIT]  = q.die_sel;
				prdata[nsc_pkg::STAT_RB_BIT]   = ready_busy_n;
			end
			nsc_pkg::ADDR_DATA: prdata[7:0] = q.data_byte;
			default: ;
		endcase
	end

	// Next-state logic for registers and the pin sequencer.
	always_comb begin
		logic [2:0] req;
		logic       bad;
		n    = q;
		item = seq_item(q.op, q.step, q.row, q.col, q.pd);
		req  = pwdata[nsc_pkg::CTRL_OP_LSB +: 3];
		bad  = 1'b0;
		// Setup registers only change while idle, so a running
		// sequence never sees its address move underneath it.
		if (wr_acc && q.st == nsc_pkg::S_IDLE) begin
			unique case (paddr)
				nsc_pkg::ADDR_ROW: n.row = pwdata[23:0];
				nsc_pkg::ADDR_COL: n.col = pwdata[15:0];
				nsc_pkg::ADDR_PD:  n.pd  = pwdata[1:0];
				default: ;
			endcase
		end
		unique case (q.st)
			nsc_pkg::S_IDLE: begin
				if (wr_acc && paddr == nsc_pkg::ADDR_CTRL) begin
					n.multi_die = pwdata[nsc_pkg::CTRL_MULTI_BIT];
					n.otp_block = pwdata[nsc_pkg::CTRL_OTP_BIT];
					// Plain 70h is unsafe with several dies. [R14]
					if (req == nsc_pkg::OP_STATUS &&
					    pwdata[nsc_pkg::CTRL_MULTI_BIT]) begin
						bad = 1'b1;
					end
					// No 78h while the OTP bit is set; power-on reset is not checked. [R18]
					if (req == nsc_pkg::OP_STATUS_ENH &&
					    pwdata[nsc_pkg::CTRL_OTP_BIT]) begin
						bad = 1'b1;
					end
					// A die must be picked by 78h first. [R23]
					if (req == nsc_pkg::OP_COL_READ &&
					    pwdata[nsc_pkg::CTRL_MULTI_BIT] && !q.die_sel) begin
						bad = 1'b1;
					end
					// Data mode only once the die is ready. [R17]
					if (req == nsc_pkg::OP_READ_MODE &&
					    !q.status_byte[nsc_pkg::SR_DIE_READY]) begin
						bad = 1'b1;
					end
					if (req > nsc_pkg::OP_READ_MODE) begin
						bad = 1'b1;
					end
					n.refused = bad;
					if (!bad && req != nsc_pkg::OP_NONE) begin
						n.op      = req;
						n.step    = 4'h0;
						n.st      = nsc_pkg::S_NEXT;
						n.pins.ce_n = 1'b0;
					end
				end
			end
			nsc_pkg::S_NEXT: begin
				// Set up lines one cycle before the strobe falls.
				n.pins.cle    = (item.kind == nsc_pkg::K_CMD);
				n.pins.ale    = (item.kind == nsc_pkg::K_ADDR);
				n.pins.io_out = item.data;
				n.pins.io_oe  = (item.kind != nsc_pkg::K_READ) &&
				                (item.kind != nsc_pkg::K_WHR) &&
				                (item.kind != nsc_pkg::K_BUSY) &&
				                (item.kind != nsc_pkg::K_END);
				unique case (item.kind)
					nsc_pkg::K_WHR: begin
						// Hold off output after last command. [R21]
						n.st  = nsc_pkg::S_WAIT;
						n.cnt = CNT_W'(nsc_pkg::WHR_CYC);
					end
					nsc_pkg::K_BUSY: begin
						// Let the target raise busy, then poll it. [R25]
						n.st  = nsc_pkg::S_BUSY;
						n.cnt = CNT_W'(nsc_pkg::FEAT_CYC);
					end
					nsc_pkg::K_END: begin
						n.st        = nsc_pkg::S_IDLE;
						n.pins.ce_n = 1'b1;
						// Track whether a die was picked by 78h. [R16]
						if (q.op == nsc_pkg::OP_STATUS_ENH) begin
							n.die_sel = 1'b1;
						end
					end
					default: n.st = nsc_pkg::S_STRB;
				endcase
			end
			nsc_pkg::S_STRB: begin
				// Drive the strobe low for the least pulse width.
				n.pins.we_n = (item.kind == nsc_pkg::K_READ);
				n.pins.re_n = (item.kind != nsc_pkg::K_READ);
				n.st  = nsc_pkg::S_LOW;
				n.cnt = CNT_W'(nsc_pkg::STROBE_CYC);
			end
			nsc_pkg::S_LOW: begin
				if (q.cnt <= CNT_W'(1)) begin
					n.pins.we_n = 1'b1;
					n.pins.re_n = 1'b1;
					n.st  = nsc_pkg::S_HIGH;
					n.cnt = CNT_W'(nsc_pkg::STROBE_CYC);
					// Sample just before the rising edge. [R4]
					if (item.kind == nsc_pkg::K_READ) begin
						if (q.op == nsc_pkg::OP_COL_READ) begin
							n.data_byte = nand_io_in; // [R22]
						end else begin
							n.status_byte = nand_io_in; // [R3]
						end
					end
				end else begin
					n.cnt = q.cnt - CNT_W'(1);
				end
			end
			nsc_pkg::S_HIGH: begin
				// Hold lines through the high half, then release.
				if (q.cnt <= CNT_W'(1)) begin
					n.pins.cle   = 1'b0;
					n.pins.ale   = 1'b0;
					n.pins.io_oe = 1'b0;
					n.step = q.step + 4'h1;
					n.st   = nsc_pkg::S_NEXT;
				end else begin
					n.cnt = q.cnt - CNT_W'(1);
				end
			end
			nsc_pkg::S_WAIT: begin
				if (q.cnt <= CNT_W'(1)) begin
					n.step = q.step + 4'h1;
					n.st   = nsc_pkg::S_NEXT;
				end else begin
					n.cnt = q.cnt - CNT_W'(1);
				end
			end
			nsc_pkg::S_BUSY: begin
				// Stays here until the busy pin rises; no timeout.
				if (q.cnt > CNT_W'(1)) begin
					n.cnt = q.cnt - CNT_W'(1);
				end else if (ready_busy_n) begin
					n.step = q.step + 4'h1;
					n.st   = nsc_pkg::S_NEXT;
				end
			end
			// The eighth state code is never reached; recover to idle.
			default: n.st = nsc_pkg::S_IDLE;
		endcase
	end

	// Single state register; chip select and both strobes idle-high after reset.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q             <= '0;
			q.st          <= nsc_pkg::S_IDLE;
			q.pd          <= nsc_pkg::PD_FULL; // [R2]
			q.pins.ce_n   <= 1'b1;
			q.pins.we_n   <= 1'b1;
			q.pins.re_n   <= 1'b1;
		end else begin
			q <= n;
		end
	end
endmodule : nsc_host

`default_nettype wire

// >>> testbench/nsc_nand_model.sv
`timescale 1ns/100ps
`default_nettype none

// Behavioural flash die; it reacts to strobe edges and has no clock.
module nsc_nand_model #(
	parameter int BUSY_NS = 2000
) (
	input  wire nsc_pkg::nsc_pins_t pins,
	input  wire logic [7:0]         st_set,
	output logic [7:0]              io_drv,
	output logic                    rb_n
);
	logic [7:0]  ready_busy_pulldown_setting = 8'h00; // Full at power-on.
	logic [23:0] rsv_params = 24'h000000; // Last P2 to P4 seen.
	logic [23:0] abuf       = 24'h000000; // Address bytes, low first.
	logic [7:0]  cmd        = 8'h00;      // Last command byte.
	logic [7:0]  last       = 8'h00;      // Last byte put on the bus.
	logic [15:0] col        = 16'h0000;   // Column latched by the confirm.
	logic [15:0] rd_cnt     = 16'h0000;   // Data bytes read so far.
	logic [15:0] rd_mark    = 16'h0000;   // Read count at the last confirm.
	logic        busy       = 1'b0;       // Die busy after a feature write.
	logic        stat_out   = 1'b0;       // Status output mode.
	logic        sel        = 1'b1;       // Die selected for output.
	int          acnt       = 0;          // Address and parameter count.
	// One status byte for this die; bit 2 is forced low.
	wire [7:0] die_status = {st_set[7], !busy, !busy && st_set[5],
		st_set[4:3], 1'b0, st_set[1:0]};
	// Cache content is a pattern of the column, so any byte is reachable.
	// Each strobe process owns its own counters, so no variable has two drivers.
	wire [15:0] cur = col + (rd_cnt - rd_mark);
	wire [7:0] cache = cur[7:0] ^ cur[15:8] ^ 8'h5A;
	assign rb_n = !busy; // Pulled up while ready.
	// Released bus shows the inverse of the last byte, never a stale copy.
	assign io_drv = (!pins.ce_n && !pins.re_n && sel) ?
		(stat_out ? die_status : cache) : ~last;
	// Each read strobe ends one output byte; data mode steps the column.
	always @(posedge pins.re_n) if (!pins.ce_n && sel) begin
		last <= stat_out ? die_status : cache;
		if (!stat_out) rd_cnt <= rd_cnt + 16'h0001;
	end
	// Commands, addresses and parameters latch on the write strobe rise.
	always @(posedge pins.we_n) if (!pins.ce_n) begin
		if (pins.cle) begin
			cmd  <= pins.io_out;
			acnt <= 0;
			case (pins.io_out)
				8'h70: begin
					stat_out <= 1'b1; // Accepted even while busy.
					sel      <= 1'b1;
				end
				8'hE0: begin
					stat_out <= 1'b0; // New column, data output.
					col      <= abuf[15:0];
					rd_mark  <= rd_cnt;
				end
				8'h00: stat_out <= 1'b0; // Back to data output.
				default: ;
			endcase
		end else if (pins.ale) begin
			abuf[8*acnt +: 8] <= pins.io_out;
			acnt <= acnt + 1;
			// Third row byte names the die; others drop off the bus.
			if (cmd == 8'h78 && acnt == 2) begin
				stat_out <= 1'b1;
				sel      <= (pins.io_out[0] == 1'b0);
			end
		end else if (cmd == 8'hEF) begin
			acnt <= acnt + 1;
			if (acnt == 1 && abuf[7:0] == 8'h81) begin
				ready_busy_pulldown_setting <= {6'h00, pins.io_out[1:0]};
			end
			if (acnt > 1) rsv_params[8*(acnt-2) +: 8] <= pins.io_out;
			if (acnt == 4) begin
				busy <= 1'b1; // Busy after the fourth parameter.
				busy <= #(BUSY_NS) 1'b0;
			end
		end
	end
endmodule : nsc_nand_model

`default_nettype wire

// >>> testbench/nsc_checker.sv
`timescale 1ns/100ps
`default_nettype none

// Watches the controller's ports; all checks run on the bus clock.
module nsc_checker (
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire logic [11:0]        paddr,
	input wire logic [31:0]        pwdata,
	input wire logic [31:0]        prdata,
	input wire logic               pready,
	input wire logic               pslverr,
	input wire nsc_pkg::nsc_pins_t nand_pins,
	input wire logic [7:0]         nand_io_in,
	input wire logic               ready_busy_n
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// A command byte latched by the rise of the write strobe.
	sequence s_cmd_latched(logic [7:0] code);
		$rose(nand_pins.we_n) && nand_pins.cle && nand_pins.io_out == code;
	endsequence
	AST_RDY: assert property (psel && penable |-> pready)
		else $error("access phase without ready");
	AST_ERR: assert property (psel && penable && paddr > 12'h014 |-> pslverr)
		else $error("unmapped access not flagged");
	AST_WHR: assert property (s_cmd_latched(8'hE0) |-> nand_pins.re_n[*4])
		else $error("read strobe too soon after confirm");
	AST_COL: assert property (s_cmd_latched(8'h05) |-> ##[1:12] nand_pins.ale)
		else $error("no column address after 05h");
	AST_STB: assert property ($fell(nand_pins.we_n) |-> ##1 !nand_pins.we_n)
		else $error("write strobe too short");
	AST_CE: assert property (!nand_pins.we_n || !nand_pins.re_n |-> !nand_pins.ce_n)
		else $error("strobe without chip select");
	AST_OE: assert property (!nand_pins.re_n |-> !nand_pins.io_oe)
		else $error("controller drives bus while reading");
	AST_LAT: assert property (!(nand_pins.cle && nand_pins.ale))
		else $error("command and address latch both high");
	AST_HOLD: assert property (!nand_pins.we_n && $past(nand_pins.we_n) == 1'b0
		|-> $stable(nand_pins.io_out))
		else $error("bus byte moved under the write strobe");
endmodule : nsc_checker

bind nsc_host nsc_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.nand_pins(nand_pins), .nand_io_in(nand_io_in),
	.ready_busy_n(ready_busy_n));

`default_nettype wire

// >>> testbench/test_nand_status_and_column_read.sv
`timescale 1ns/100ps
`default_nettype none

`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
	$display("unexpected t=%0t got %h exp %h", $time, a, b); end end

module test_nand_status_and_column_read;
	logic               pclk    = 1'b0;
	logic               presetn = 1'b0;
	logic               psel    = 1'b0;
	logic               penable = 1'b0;
	logic               pwrite  = 1'b0;
	logic [11:0]        paddr   = 12'h000;
	logic [31:0]        pwdata  = 32'h0;
	logic [7:0]         st_set  = 8'h00;  // Die condition bits.
	logic [31:0]        prdata, s, d;
	logic               pready, pslverr, rb_n, e;
	logic [7:0]         dev_io, io_in;
	logic [15:0]        col;
	logic [23:0]        row;
	nsc_pkg::nsc_pins_t nand_pins;
	int                 n_fail = 0, checked = 0, cyc = 0, seed;
	always #10 pclk = ~pclk;
	// The bus carries the controller's byte while it drives, else the die's.
	assign io_in = nand_pins.io_oe ? nand_pins.io_out : dev_io;
	nsc_host u_nsc_host (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.nand_pins(nand_pins), .nand_io_in(io_in), .ready_busy_n(rb_n));
	nsc_nand_model u_dev (.pins(nand_pins), .st_set(st_set),
		.io_drv(dev_io), .rb_n(rb_n));
	// Status seen from an idle die; bit 2 always low.
	function automatic logic [7:0] exp_stat(input logic [7:0] v);
		return {v[7], 1'b1, v[5], v[4:3], 1'b0, v[1:0]};
	endfunction : exp_stat
	// One APB transfer; the request holds until ready is sampled high.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] wd, output logic [31:0] r, output logic er);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Writes an order, then polls until the controller is idle again.
	task automatic run(input logic [31:0] ctrl, output logic [31:0] st);
		logic [31:0] r;
		logic er;
		apb(1'b1, nsc_pkg::ADDR_CTRL, ctrl, r, er);
		do apb(1'b0, nsc_pkg::ADDR_STAT, 32'h0, st, er);
		while (st[nsc_pkg::STAT_BUSY_BIT] !== 1'b0);
	endtask : run
	task automatic give_verdict;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : give_verdict
	// A hang counts as a mismatch and closes the run.
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 60000) begin
			n_fail++;
			give_verdict();
		end
	end
	initial begin
		seed = $urandom(32'h2bb4);
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		`CHK(u_dev.ready_busy_pulldown_setting, 8'h00)
		// Every strength code, ending back at full.
		for (int i = 1; i <= 4; i++) begin
			apb(1'b1, nsc_pkg::ADDR_PD, 32'(i % 4), d, e);
			run(32'(nsc_pkg::OP_SET_PD), s);
			`CHK(u_dev.ready_busy_pulldown_setting, 8'(i % 4))
			`CHK(u_dev.rsv_params, 24'h000000)
		end
		// Plain status; the first pass sets every condition bit.
		for (int i = 0; i < 6; i++) begin
			st_set <= (i == 0) ? 8'hFF : 8'($urandom);
			run(32'(nsc_pkg::OP_STATUS), s);
			`CHK(s[7:0], exp_stat(st_set))
		end
		// Enhanced status to die 0 with random page and block.
		for (int i = 0; i < 4; i++) begin
			st_set <= 8'($urandom);
			row = 24'($urandom) & 24'hFEFFFF;
			apb(1'b1, nsc_pkg::ADDR_ROW, {8'h00, row}, d, e);
			apb(1'b0, nsc_pkg::ADDR_ROW, 32'h0, d, e);
			`CHK(d, {8'h00, row})
			run(32'(nsc_pkg::OP_STATUS_ENH), s);
			`CHK(s[7:0], exp_stat(st_set))
			`CHK(s[nsc_pkg::STAT_SEL_BIT], 1'b1)
		end
		// Column reads back to back, edge columns first.
		for (int i = 0; i < 6; i++) begin
			col = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : 16'($urandom);
			apb(1'b1, nsc_pkg::ADDR_COL, {16'h0000, col}, d, e);
			apb(1'b0, nsc_pkg::ADDR_COL, 32'h0, d, e);
			`CHK(d, {16'h0000, col})
			run(32'(nsc_pkg::OP_COL_READ), s);
			apb(1'b0, nsc_pkg::ADDR_DATA, 32'h0, d, e);
			`CHK(d[7:0], col[7:0] ^ col[15:8] ^ 8'h5A)
		end
		run(32'(nsc_pkg::OP_READ_MODE), s);
		`CHK(s[nsc_pkg::STAT_REF_BIT], 1'b0)
		run(32'h10 | 32'(nsc_pkg::OP_STATUS), s);
		`CHK(s[nsc_pkg::STAT_REF_BIT], 1'b1)
		run(32'h20 | 32'(nsc_pkg::OP_STATUS_ENH), s);
		`CHK(s[nsc_pkg::STAT_REF_BIT], 1'b1)
		apb(1'b0, 12'h040, 32'h0, d, e);
		`CHK(e, 1'b1)
		// A reset while idle must restore full strength and forget the die.
		apb(1'b1, nsc_pkg::ADDR_PD, 32'h3, d, e);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, nsc_pkg::ADDR_PD, 32'h0, d, e);
		`CHK(d[1:0], nsc_pkg::PD_FULL)
		// No status captured yet, so data mode is refused.
		run(32'(nsc_pkg::OP_READ_MODE), s);
		`CHK(s[nsc_pkg::STAT_REF_BIT], 1'b1)
		// Several dies and no 78h since reset: column read is refused.
		run(32'h10 | 32'(nsc_pkg::OP_COL_READ), s);
		`CHK(s[nsc_pkg::STAT_REF_BIT], 1'b1)
		`CHK(s[nsc_pkg::STAT_SEL_BIT], 1'b0)
		give_verdict();
	end
endmodule : test_nand_status_and_column_read

`default_nettype wire
